// ---- timer_status_flags.sv ----
// status flags, interrupt gating and register slave of a general timer
//
// Contract
// - update flag bit 0 sets on any update event; only writing zero clears it (a one written to the clear alias at 0x60 also clears it here).
// - with update disable zero, counter over/underflow raises an update event.
// - update-generate with both controls zero gives update event and reinit.
// - with both controls zero, trigger reinit of counter raises update event.
// - output channel 1 sets its flag (bit 1) on counter equal compare value.
// - input channel 1 sets its flag on an input capture event.
// - channel 1 flag clears on write of zero or read of its value register.
// - channels 2..4 flags in bits 2..4 behave exactly like channel 1.
// - trigger flag bit 6 sets on trigger event; only writing zero clears it (a one written to the clear alias at 0x60 also clears it here).
// - overcapture bit 9 sets when capture hits while channel 1 flag set.
// - overcapture flags for channels 2..4 sit in bits 10..12, same behaviour.
// - status register at offset 0x10, all flags zero after reset.
// - each flag raises the interrupt only when its enable bit is one.
// - channel event-generate sets the flag; input channel also captures count.
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none

module timer_status_flags
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // avalon-mm slave
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // timer datapath events and configuration
    input wire timer_flags_pkg::timer_events_t events_i,
    input wire logic [timer_flags_pkg::NUM_CHAN-1:0] chan_input_mode_i,
    input wire logic [timer_flags_pkg::CNT_W-1:0] counter_value_i,
    // results towards the timer and the cpu
    output logic update_event_o,
    output logic counter_reinit_o,
    output logic irq_o
);
    import timer_flags_pkg::*;

    // ------------------------------------------------------------------
    // bus handshake: one wait cycle, then the request is taken
    // ------------------------------------------------------------------
    avs_req_t req;
    logic req_any;
    logic accept;
    logic wait_nxt;
    logic wr_acc;
    logic rd_acc;

    assign req.address = avs_address_i;
    assign req.read = avs_read_i;
    assign req.write = avs_write_i;
    assign req.byteenable = avs_byteenable_i;
    assign req.writedata = avs_writedata_i;
    assign req_any = req.read | req.write;
    // the request is taken at the edge where waitrequest is sampled low
    assign accept = req_any & ~avs_waitrequest_o;
    assign wait_nxt = avs_waitrequest_o ? ~req_any : 1'b1;
    assign wr_acc = accept & req.write;
    assign rd_acc = accept & req.read;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    logic sel_control;
    logic sel_ien;
    logic sel_status;
    logic sel_evgen;
    logic sel_sclr;
    logic [NUM_CHAN-1:0] sel_chan;
    logic [15:0] wmask;

    assign sel_control = (req.address == OFS_CONTROL);
    assign sel_ien = (req.address == OFS_IRQ_ENABLE);
    assign sel_status = (req.address == OFS_STATUS);
    assign sel_evgen = (req.address == OFS_EVENT_GEN);
    assign sel_sclr = (req.address == OFS_STATUS_CLEAR);
    // only lanes 0 and 1 carry the 16-bit registers
    assign wmask = {{8{req.byteenable[1]}}, {8{req.byteenable[0]}}};

    genvar gc;
    generate
        for (gc = 0; gc < NUM_CHAN; gc++)
        begin : g_dec
            assign sel_chan[gc] =
                (req.address == OFS_CHAN_VALUE0 + 8'(4 * gc));
        end
    endgenerate

    // ------------------------------------------------------------------
    // control and enable registers
    // ------------------------------------------------------------------
    logic [2:0] control_r;
    logic [15:0] ien_r;
    logic update_disable;
    logic update_req_sel;
    logic [2:0] control_nxt;
    logic [15:0] ien_nxt;

    assign update_disable = control_r[BIT_UPDATE_DISABLE];
    assign update_req_sel = control_r[BIT_UPDATE_REQ_SEL];
    assign control_nxt = (wr_acc & sel_control & req.byteenable[0]) ?
        req.writedata[2:0] : control_r;
    // enables exist only where a status flag is implemented
    assign ien_nxt = (wr_acc & sel_ien) ?
        (((req.writedata[15:0] & wmask) | (ien_r & ~wmask))
         & STATUS_IMPL_MASK) : ien_r;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            control_r <= CONTROL_RESET;
            ien_r <= STATUS_RESET;
        end
        else
        begin
            control_r <= control_nxt;
            ien_r <= ien_nxt;
        end
    end

    // ------------------------------------------------------------------
    // software event generation (self-clearing, so a pulse only)
    // ------------------------------------------------------------------
    logic evgen_wr;
    logic sw_update_gen;
    logic sw_trigger_gen;
    logic [NUM_CHAN-1:0] sw_chan_gen;

    assign evgen_wr = wr_acc & sel_evgen & req.byteenable[0];
    assign sw_update_gen = evgen_wr & req.writedata[BIT_UPDATE];
    assign sw_trigger_gen = evgen_wr & req.writedata[BIT_TRIGGER];
    assign sw_chan_gen =
        {NUM_CHAN{evgen_wr}} & req.writedata[BIT_CHAN0 +: NUM_CHAN];

    // ------------------------------------------------------------------
    // update event sources
    // ------------------------------------------------------------------
    logic upd_overflow;
    logic upd_sw;
    logic upd_trig;
    logic update_event;

    assign upd_overflow = events_i.overflow & ~update_disable;
    // software and trigger reinit count only with both controls clear
    assign upd_sw = sw_update_gen & ~update_disable & ~update_req_sel;
    assign upd_trig = events_i.trigger_reinit & ~update_disable
        & ~update_req_sel;
    assign update_event = upd_overflow | upd_sw | upd_trig;

    // ------------------------------------------------------------------
    // channel set conditions and captured values
    // ------------------------------------------------------------------
    logic [15:0] status;
    logic [NUM_CHAN-1:0] chan_hw_hit;
    logic [NUM_CHAN-1:0] chan_set;
    logic [NUM_CHAN-1:0] chan_capture;
    logic [NUM_CHAN-1:0] chan_rd_clear;
    logic [NUM_CHAN-1:0] overcap_set;
    logic [CNT_W-1:0] chan_value_r [NUM_CHAN];

    genvar gh;
    generate
        for (gh = 0; gh < NUM_CHAN; gh++)
        begin : g_chan
            logic [CNT_W-1:0] value_nxt;
            logic chan_wr;

            // output channels see compare matches, inputs see captures
            assign chan_hw_hit[gh] = chan_input_mode_i[gh] ?
                events_i.capture[gh] :
                events_i.compare_match[gh];
            assign chan_set[gh] = chan_hw_hit[gh] | sw_chan_gen[gh];
            // a software event on an input channel also captures the count
            assign chan_capture[gh] = chan_input_mode_i[gh] &
                (events_i.capture[gh] | sw_chan_gen[gh]);
            // capture while the event flag still stands is a repeat
            assign overcap_set[gh] = chan_capture[gh]
                & status[BIT_CHAN0 + gh];
            assign chan_rd_clear[gh] = rd_acc & sel_chan[gh];
            // compare value is writable only while the channel is an output
            assign chan_wr = wr_acc & sel_chan[gh] & ~chan_input_mode_i[gh];
            assign value_nxt = chan_capture[gh] ? counter_value_i :
                chan_wr ? ((req.writedata[15:0] & wmask)
                           | (chan_value_r[gh] & ~wmask)) :
                chan_value_r[gh];

            always_ff @(posedge clk_sys_i or posedge rst_i)
            begin
                if (rst_i)
                    chan_value_r[gh] <= CHAN_VALUE_RESET;
                else
                    chan_value_r[gh] <= value_nxt;
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // flag set and clear vectors
    // ------------------------------------------------------------------
    logic [15:0] flag_set;
    logic [15:0] flag_clr;
    logic [15:0] w0_clear;
    logic [15:0] sclr_clear;

    always_comb
    begin
        flag_set = STATUS_RESET;
        flag_set[BIT_UPDATE] = update_event;
        flag_set[BIT_CHAN0 +: NUM_CHAN] = chan_set;
        flag_set[BIT_TRIGGER] = events_i.trigger | sw_trigger_gen;
        flag_set[BIT_OVERCAP0 +: NUM_CHAN] = overcap_set;
    end

    // writing zero clears, writing one leaves the flag alone
    assign w0_clear = {16{wr_acc & sel_status}} & wmask
        & ~req.writedata[15:0];
    // write-one-to-clear alias for interrupt service code
    assign sclr_clear = {16{wr_acc & sel_sclr}} & wmask
        & req.writedata[15:0];
    always_comb
    begin
        flag_clr = w0_clear | sclr_clear;
        flag_clr[BIT_CHAN0 +: NUM_CHAN] =
            w0_clear[BIT_CHAN0 +: NUM_CHAN]
            | sclr_clear[BIT_CHAN0 +: NUM_CHAN]
            | chan_rd_clear;
    end

    // ------------------------------------------------------------------
    // status flag cells; reserved positions are constant zero
    // ------------------------------------------------------------------
    genvar gf;
    generate
        for (gf = 0; gf < STATUS_W; gf++)
        begin : g_flag
            if (STATUS_IMPL_MASK[gf])
            begin : g_impl
                flag_bit_cell u_cell
                (
                    .clk_sys_i(clk_sys_i),
                    .rst_i(rst_i),
                    .set_i(flag_set[gf]),
                    .clr_i(flag_clr[gf]),
                    .flag_o(status[gf])
                );
            end
            else
            begin : g_rsvd
                assign status[gf] = 1'b0;
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // read data mux; unmapped and write-only offsets read zero
    // ------------------------------------------------------------------
    logic [15:0] chan_rd;
    logic [15:0] rd_word;

    always_comb
    begin
        chan_rd = 16'h0000;
        for (int i = 0; i < NUM_CHAN; i++)
            if (sel_chan[i])
                chan_rd = chan_value_r[i];
    end

    assign rd_word = sel_control ? {13'h0000, control_r} :
        sel_ien ? ien_r :
        sel_status ? status :
        |sel_chan ? chan_rd : 16'h0000;

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    logic irq_nxt;
    logic [31:0] rdata_nxt;

    // interrupt follows flags only where enabled; latency one cycle
    assign irq_nxt = |(status & ien_r);
    // read data is loaded in the wait cycle and stands at the accept edge
    assign rdata_nxt = (req.read & avs_waitrequest_o) ?
        {16'h0000, rd_word} : avs_readdata_o;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0000_0000;
            update_event_o <= 1'b0;
            counter_reinit_o <= 1'b0;
            irq_o <= 1'b0;
        end
        else
        begin
            avs_waitrequest_o <= wait_nxt;
            avs_readdata_o <= rdata_nxt;
            update_event_o <= update_event;
            counter_reinit_o <= sw_update_gen;
            irq_o <= irq_nxt;
        end
    end

endmodule : timer_status_flags

`default_nettype wire

// ---- timer_flags_pkg.sv ----
// package: register map, field positions and carriers of the timer flag block
package timer_flags_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_EVENT_GEN = 8'h14;
    localparam logic [7:0] OFS_CHAN_VALUE0 = 8'h34;
    localparam logic [7:0] OFS_STATUS_CLEAR = 8'h60;

    // ------------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------------
    localparam int STATUS_W = 16;
    localparam int NUM_CHAN = 4;
    localparam int CNT_W = 16;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] CHAN_VALUE_RESET = 16'h0000;
    localparam logic [2:0] CONTROL_RESET = 3'h0;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BIT_UPDATE = 0;
    localparam int BIT_CHAN0 = 1;
    localparam int BIT_TRIGGER = 6;
    localparam int BIT_OVERCAP0 = 9;
    localparam int BIT_UPDATE_DISABLE = 1;
    localparam int BIT_UPDATE_REQ_SEL = 2;
    // implemented status bits; bits 5, 7, 8 and 13..15 are reserved
    localparam logic [15:0] STATUS_IMPL_MASK = 16'h1e5f;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    // one-cycle strobes from the counter and capture/compare datapath
    typedef struct packed {
        logic overflow;                  // counter over- or underflow
        logic trigger_reinit;            // trigger event reinitialised counter
        logic trigger;                   // trigger event generated
        logic [NUM_CHAN-1:0] compare_match;
        logic [NUM_CHAN-1:0] capture;
    } timer_events_t;

    // avalon-mm request as seen by the slave
    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } avs_req_t;

endpackage : timer_flags_pkg

// ---- flag_bit_cell.sv ----
// one sticky status flag where a hardware set beats a clear
`timescale 1ns/10ps
`default_nettype none

module flag_bit_cell
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // set and clear strobes
    input wire logic set_i,
    input wire logic clr_i,
    // flag
    output logic flag_o
);

    // ------------------------------------------------------------------
    // sticky flag
    // ------------------------------------------------------------------
    logic flag_nxt;

    // set wins over a clear in the same cycle so no event is lost
    assign flag_nxt = set_i | (flag_o & ~clr_i);

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            flag_o <= 1'b0;
        else
            flag_o <= flag_nxt;
    end

endmodule : flag_bit_cell

`default_nettype wire

// ---- timer_status_flags_checker.sv ----
// checker: bus, update and interrupt relations of the timer flag block
`timescale 1ns/10ps
`default_nettype none

module timer_status_flags_checker
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // avalon-mm slave
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // timer side
    input wire timer_flags_pkg::timer_events_t events_i,
    input wire logic update_event_o,
    input wire logic counter_reinit_o,
    input wire logic irq_o
);
    import timer_flags_pkg::*;
    // ----------------------------------------------------------------
    // shadow of control and enable, rebuilt from accepted writes
    // ----------------------------------------------------------------
    logic [1:0] ctrl_r;
    logic [15:0] en_r;
    wire logic wr_acc;
    wire logic ctrl_wr;
    wire logic en_wr;
    wire logic ug_wr;
    wire logic upd_ok;
    wire logic upd_cause;
    // only full low-half enable writes are shadowed; the bench uses no other
    assign wr_acc = avs_write_i & ~avs_waitrequest_o;
    assign ctrl_wr = wr_acc & avs_byteenable_i[0]
        & (avs_address_i == OFS_CONTROL);
    assign en_wr = wr_acc & (&avs_byteenable_i[1:0])
        & (avs_address_i == OFS_IRQ_ENABLE);
    assign ug_wr = wr_acc & avs_byteenable_i[0] & avs_writedata_i[0]
        & (avs_address_i == OFS_EVENT_GEN);
    assign upd_ok = (ctrl_r == 2'h0);
    assign upd_cause = (events_i.overflow & ~ctrl_r[0])
        | ((events_i.trigger_reinit | ug_wr) & upd_ok);

    // control bits 2:1 and enable bits follow accepted writes
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctrl_r <= 2'h0;
            en_r <= 16'h0000;
        end
        else
        begin
            if (ctrl_wr)
                ctrl_r <= avs_writedata_i[2:1];
            if (en_wr)
                en_r <= avs_writedata_i[15:0] & STATUS_IMPL_MASK;
        end
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence req_first_s;
        (avs_read_i | avs_write_i) & avs_waitrequest_o;
    endsequence
    sequence accept_s;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    sequence ug_s;
        ug_wr ##1 counter_reinit_o;
    endsequence

    bus_one_wait_a: assert property (req_first_s |=> accept_s)
        else $error("bus wait is not one cycle");
    reset_idle_a: assert property ($fell(rst_i) |->
        avs_waitrequest_o && !irq_o && avs_readdata_o == 32'h0)
        else $error("outputs not idle after reset");
    reserved_zero_a: assert property (avs_read_i && !avs_waitrequest_o
        && avs_address_i == OFS_STATUS |->
        (avs_readdata_o & ~{16'h0000, STATUS_IMPL_MASK}) == 32'h0)
        else $error("reserved status bits read nonzero");
    ovf_update_a: assert property (events_i.overflow && !ctrl_r[0]
        |=> update_event_o) else $error("overflow gave no update");
    reinit_update_a: assert property (events_i.trigger_reinit
        && upd_ok |=> update_event_o) else $error("reinit gave no update");
    ug_reinit_a: assert property (ug_wr |-> ug_s)
        else $error("update generate gave no reinit");
    update_cause_a: assert property (update_event_o |->
        $past(upd_cause)) else $error("update event without cause");
    irq_mask_a: assert property (en_r == 16'h0000 |=> !irq_o)
        else $error("irq with all enables off");
    irq_raise_a: assert property (events_i.trigger
        && en_r[BIT_TRIGGER] && !en_wr |-> ##2 irq_o)
        else $error("enabled trigger gave no irq");
endmodule : timer_status_flags_checker

bind timer_status_flags timer_status_flags_checker chk_i (.*);

`default_nettype wire

// ---- timer_status_flags_tb.sv ----
// testbench: register-level tests of the timer flag block
`timescale 1ns/10ps
`default_nettype none

module timer_status_flags_tb;
    import timer_flags_pkg::*;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk_sys_i;
    logic rst_i;
    logic [7:0] avs_address_i;
    logic avs_read_i;
    logic avs_write_i;
    logic [3:0] avs_byteenable_i;
    logic [31:0] avs_writedata_i;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    timer_events_t events_i;
    logic [NUM_CHAN-1:0] chan_input_mode_i;
    logic [CNT_W-1:0] counter_value_i;
    logic update_event_o;
    logic counter_reinit_o;
    logic irq_o;
    timer_events_t e;
    logic [7:0] ca;
    logic [15:0] q;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;

    timer_status_flags uut
    (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .events_i(events_i),
        .chan_input_mode_i(chan_input_mode_i),
        .counter_value_i(counter_value_i), .update_event_o(update_event_o),
        .counter_reinit_o(counter_reinit_o), .irq_o(irq_o)
    );

    // clock, and a cycle ceiling well above the few hundred cycles needed
    initial
    begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            err_total = err_total + 1;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input string s, input logic [15:0] g,
        input logic [15:0] x);
        n_checks++;
        if (g !== x)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", s, x, g);
        end
    endtask : chk

    // one bus cycle; ev strobes stand until the accept edge, so they
    // meet the write at that edge whatever the wait count
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [15:0] d, input timer_events_t ev);
        @(posedge clk_sys_i);
        avs_address_i <= a;
        avs_write_i <= w;
        avs_read_i <= ~w;
        avs_writedata_i <= {16'h0000, d};
        events_i <= ev;
        do
            @(posedge clk_sys_i);
        while (avs_waitrequest_o !== 1'b0);
        // waitrequest and read data as sampled at the accept edge
        q = avs_readdata_o[15:0];
        chk("readdata_hi", avs_readdata_o[31:16], 16'h0000);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        events_i <= '0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, d, '0);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [15:0] x);
        bus(1'b0, a, 16'h0000, '0);
        chk($sformatf("reg_%h", a), q, x);
    endtask : rdc

    task automatic pulse(input timer_events_t ev);
        @(posedge clk_sys_i);
        events_i <= ev;
        @(posedge clk_sys_i);
        events_i <= '0;
    endtask : pulse

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        rst_i = 1'b1;
        avs_address_i = 8'h00;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_byteenable_i = 4'h3;
        avs_writedata_i = 32'h0;
        events_i = '0;
        chan_input_mode_i = 4'h0;
        counter_value_i = 16'h0000;
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rdc(OFS_STATUS, STATUS_RESET);
        rdc(8'h50, 16'h0000);
        // k: 0 both controls clear, 1 update disable, 2 request select
        for (int k = 0; k < 3; k++)
        begin
            wr(OFS_CONTROL, {13'h0, k == 2, k == 1, 1'b0});
            e = '0;
            e.overflow = 1'b1;
            pulse(e);
            rdc(OFS_STATUS, {15'h0, k != 1});
            wr(OFS_STATUS, 16'hffff);
            rdc(OFS_STATUS, {15'h0, k != 1});
            wr(OFS_STATUS, 16'hfffe);
            rdc(OFS_STATUS, 16'h0000);
            e = '0;
            e.trigger_reinit = 1'b1;
            pulse(e);
            rdc(OFS_STATUS, {15'h0, k == 0});
            wr(OFS_STATUS, 16'h0000);
            wr(OFS_EVENT_GEN, 16'h0001);
            rdc(OFS_STATUS, {15'h0, k == 0});
            wr(OFS_STATUS, 16'h0000);
        end
        wr(OFS_CONTROL, 16'h0000);
        for (int i = 0; i < NUM_CHAN; i++)
        begin
            ca = OFS_CHAN_VALUE0 + 8'(4 * i);
            chan_input_mode_i <= 4'h0;
            e = '0;
            e.compare_match[i] = 1'b1;
            pulse(e);
            // a second match on an output channel is no overcapture
            pulse(e);
            rdc(OFS_STATUS, 16'h0001 << (1 + i));
            rdc(ca, CHAN_VALUE_RESET);
            rdc(OFS_STATUS, 16'h0000);
            chan_input_mode_i <= 4'h1 << i;
            counter_value_i <= 16'h1230 + 16'(i);
            e = '0;
            e.capture[i] = 1'b1;
            pulse(e);
            rdc(OFS_STATUS, 16'h0001 << (1 + i));
            pulse(e);
            rdc(OFS_STATUS, 16'h0202 << i);
            rdc(ca, 16'h1230 + 16'(i));
            rdc(OFS_STATUS, 16'h0200 << i);
            wr(OFS_STATUS, ~(16'h0200 << i));
            rdc(OFS_STATUS, 16'h0000);
            counter_value_i <= 16'h4560 + 16'(i);
            wr(OFS_EVENT_GEN, 16'h0001 << (1 + i));
            rdc(OFS_STATUS, 16'h0001 << (1 + i));
            wr(OFS_STATUS, 16'h0000);
            rdc(OFS_STATUS, 16'h0000);
            rdc(ca, 16'h4560 + 16'(i));
        end
        // trigger flag, interrupt gating, and set against clear
        wr(OFS_IRQ_ENABLE, 16'h0040);
        e = '0;
        e.trigger = 1'b1;
        pulse(e);
        // the flag sets at the strobe edge, irq_o one edge later
        @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk("irq_o", {15'h0, irq_o}, 16'h0001);
        rdc(OFS_STATUS, 16'h0040);
        wr(OFS_STATUS_CLEAR, 16'h0040);
        rdc(OFS_STATUS, 16'h0000);
        wr(OFS_IRQ_ENABLE, 16'h0000);
        pulse(e);
        @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk("irq_o", {15'h0, irq_o}, 16'h0000);
        wr(OFS_STATUS, 16'h0000);
        bus(1'b1, OFS_STATUS, 16'h0000, e);
        rdc(OFS_STATUS, 16'h0040);
        end_sim();
    end
endmodule : timer_status_flags_tb

`default_nettype wire
